// *** dsf_pkg.sv ***
// Shared constants and types for the disk sector framer.
package dsf_pkg;
  localparam int CLK_MHZ = 250;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_GAP_NS = 3000;
  localparam int STEP_GAP_CYC = (STEP_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SECTOR_BYTES = 512;
  localparam int HDR_BYTES = 5;
  localparam int CRC_BYTES = 2;
  localparam int SPT_SMALL = 21;
  localparam int SPT_LARGE = 32;
  localparam int TRACKS_SMALL = 244;
  localparam int TRACKS_LARGE = 202;
  localparam int HEADS_SMALL = 8;
  localparam int SURF_LARGE = 4;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [7:0] TRACK_RESET = 8'h00;

  typedef enum logic [1:0] {
    DSF_OP_READ,
    DSF_OP_WRITE,
    DSF_OP_FORMAT
  } dsf_op_t;

  typedef struct packed {
    dsf_op_t op;
    logic [8:0] track;
    logic [2:0] head;
    logic [4:0] sector;
    logic [7:0] key;
    logic [7:0] secinfo;
  } dsf_cmd_t;

  typedef struct packed {
    logic range_err;
    logic id_err;
    logic crc_err;
    logic pwr_abort;
  } dsf_status_t;
endpackage

// *** dsf_crc16.sv ***
// Byte-serial 16-bit check word generator and checker.
module dsf_crc16 (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [7:0] i_byte,
  output logic [15:0] o_crc
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  always_comb begin
    logic [15:0] c;
    c = i_clear ? dsf_pkg::CRC_INIT : crc_r;
    if (i_en) begin
      for (int b = 7; b >= 0; b--) begin
        c = (c[15] ^ i_byte[b]) ? ((c << 1) ^ dsf_pkg::CRC_POLY) : (c << 1);
      end
    end
    crc_nxt = c;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      crc_r <= dsf_pkg::CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign o_crc = crc_r;
endmodule // dsf_crc16

// *** dsf_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
module dsf_buf2 #(
  parameter int W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_data = mem_r[rp_r];

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_r ^ push;
      rp_r <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // dsf_buf2

// *** dsf_framer.sv ***
// Disk-side track stepping and sector framing with check words.
module dsf_framer (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_large_drive,
  input wire logic i_power_down,
  input wire logic i_track0,
  input wire logic i_cmd_valid,
  input wire dsf_pkg::dsf_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_done,
  output dsf_pkg::dsf_status_t o_status,
  output logic o_step,
  output logic o_step_in,
  output logic [2:0] o_head_sel,
  output logic [7:0] o_cur_track,
  output logic o_write_gate,
  input wire logic i_media_rd_valid,
  input wire logic [7:0] i_media_rd_byte,
  output logic o_media_rd_ready,
  output logic o_media_wr_valid,
  output logic [7:0] o_media_wr_byte,
  input wire logic i_media_wr_ready,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  input wire logic i_rd_ready
);
  typedef enum logic [3:0] {
    S_RECAL, S_IDLE, S_SEEK, S_STEP, S_GAP, S_HDR_RD, S_HCRC_RD, S_HCHK,
    S_HDR_WR, S_HCRC_WR, S_DAT_RD, S_DCRC_RD, S_DCHK, S_DAT_WR, S_DCRC_WR
  } dsf_state_t;

  dsf_state_t st_r;
  dsf_pkg::dsf_cmd_t cmd_r;
  logic [1:0] pdn_q_r, trk0_q_r, large_q_r;
  logic pdn_s, trk0_s, large_s;
  logic [7:0] cur_trk_r, tgt_trk_r;
  logic [2:0] head_r;
  logic recal_r, id_bad_r;
  logic [15:0] tmr_r;
  logic [9:0] cnt_r;
  logic [15:0] crc;
  logic crc_clr, crc_en;
  logic [7:0] crc_byte, hdr_byte;
  logic media_take, media_put, wr_state;
  logic rbuf_in_ready, wbuf_out_valid, wbuf_out_ready;
  logic [7:0] wbuf_out_byte;
  logic cmd_take, range_bad, half;
  logic [7:0] phys_trk;

  // Pin inputs pass two flip-flops before anything reads them.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pdn_q_r <= 2'b11;
      trk0_q_r <= 2'b00;
      large_q_r <= 2'b00;
    end else begin
      pdn_q_r <= {pdn_q_r[0], i_power_down};
      trk0_q_r <= {trk0_q_r[0], i_track0};
      large_q_r <= {large_q_r[0], i_large_drive};
    end
  end
  assign pdn_s = pdn_q_r[1];
  assign trk0_s = trk0_q_r[1];
  assign large_s = large_q_r[1];

  // The large drive splits each surface between two heads, so logical
  // tracks past the first band belong to the partner head, counted again from track zero.
  assign half = large_s && (i_cmd.track >= 9'(dsf_pkg::TRACKS_LARGE));
  assign phys_trk = half ? 8'(i_cmd.track - 9'(dsf_pkg::TRACKS_LARGE)) : i_cmd.track[7:0];
  assign range_bad = large_s ?
    (i_cmd.track >= 9'(2 * dsf_pkg::TRACKS_LARGE) || i_cmd.head >= 3'(dsf_pkg::SURF_LARGE) ||
     {1'b0, i_cmd.sector} >= 6'(dsf_pkg::SPT_LARGE)) :
    (i_cmd.track >= 9'(dsf_pkg::TRACKS_SMALL) || {1'b0, i_cmd.head} >= 4'(dsf_pkg::HEADS_SMALL) ||
     i_cmd.sector >= 5'(dsf_pkg::SPT_SMALL));

  assign o_cmd_ready = (st_r == S_IDLE);
  assign cmd_take = i_cmd_valid & o_cmd_ready;
  assign o_step = (st_r == S_STEP);
  assign o_cur_track = cur_trk_r;
  assign o_head_sel = head_r;

  // Header layout: track, head, key, sector, security byte.
  always_comb begin
    case (cnt_r[2:0])
      3'h0: hdr_byte = tgt_trk_r;
      3'h1: hdr_byte = {5'h00, head_r};
      3'h2: hdr_byte = cmd_r.key;
      3'h3: hdr_byte = {3'h0, cmd_r.sector};
      default: hdr_byte = cmd_r.secinfo;
    endcase
  end

  assign wr_state = (st_r == S_HDR_WR) || (st_r == S_HCRC_WR) ||
                    (st_r == S_DAT_WR) || (st_r == S_DCRC_WR);
  assign o_write_gate = wr_state & ~pdn_s;
  assign o_media_rd_ready = (st_r == S_HDR_RD) || (st_r == S_HCRC_RD) ||
                            (st_r == S_DCRC_RD) || ((st_r == S_DAT_RD) && rbuf_in_ready);
  assign media_take = o_media_rd_ready & i_media_rd_valid;
  assign o_media_wr_valid = ~pdn_s & ((st_r == S_HDR_WR) || (st_r == S_HCRC_WR) ||
                            (st_r == S_DCRC_WR) || ((st_r == S_DAT_WR) && wbuf_out_valid));
  assign media_put = o_media_wr_valid & i_media_wr_ready;
  assign wbuf_out_ready = (st_r == S_DAT_WR) & ~pdn_s & i_media_wr_ready;

  // Check word follows its field, high byte first.
  always_comb begin
    case (st_r)
      S_HDR_WR: o_media_wr_byte = hdr_byte;
      S_DAT_WR: o_media_wr_byte = wbuf_out_byte;
      default: o_media_wr_byte = cnt_r[0] ? crc[7:0] : crc[15:8];
    endcase
  end

  // The engine restarts at the first byte of each field; check bytes read
  // back run through it too, so a clean field leaves a zero residue.
  assign crc_clr = (cnt_r == 10'h000) && ((st_r == S_HDR_RD) || (st_r == S_HDR_WR) ||
                   (st_r == S_DAT_RD) || (st_r == S_DAT_WR));
  assign crc_en = (media_take | media_put) && (st_r != S_HCRC_WR) && (st_r != S_DCRC_WR);
  assign crc_byte = media_take ? i_media_rd_byte : o_media_wr_byte;

  dsf_crc16 u_crc (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clear(crc_clr),
    .i_en(crc_en),
    .i_byte(crc_byte),
    .o_crc(crc)
  );

  dsf_buf2 #(.W(8)) u_wbuf (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_valid(i_wr_valid),
    .i_data(i_wr_byte),
    .o_ready(o_wr_ready),
    .o_valid(wbuf_out_valid),
    .o_data(wbuf_out_byte),
    .i_ready(wbuf_out_ready)
  );

  dsf_buf2 #(.W(8)) u_rbuf (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_valid(media_take && (st_r == S_DAT_RD)),
    .i_data(i_media_rd_byte),
    .o_ready(rbuf_in_ready),
    .o_valid(o_rd_valid),
    .o_data(o_rd_byte),
    .i_ready(i_rd_ready)
  );

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_r <= '0;
      tgt_trk_r <= dsf_pkg::TRACK_RESET;
      head_r <= 3'h0;
    end else if (cmd_take) begin
      cmd_r <= i_cmd;
      tgt_trk_r <= phys_trk;
      head_r <= large_s ? {i_cmd.head[1:0], half} : i_cmd.head;
    end
  end

  // Header identity compare during readback.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      id_bad_r <= 1'b0;
    end else if (media_take && (st_r == S_HDR_RD)) begin
      id_bad_r <= ((cnt_r == 10'h000) ? 1'b0 : id_bad_r) | (i_media_rd_byte != hdr_byte);
    end
  end

  // Track position follows each completed seek step; recalibration steps leave it, and the sensor sets track zero.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_trk_r <= dsf_pkg::TRACK_RESET;
    end else if (st_r == S_RECAL && trk0_s) begin
      cur_trk_r <= dsf_pkg::TRACK_RESET;
    end else if (st_r == S_STEP && tmr_r == 16'h0001 && !recal_r) begin
      cur_trk_r <= o_step_in ? cur_trk_r + 8'h01 : cur_trk_r - 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= S_RECAL;
      recal_r <= 1'b1;
      o_step_in <= 1'b0;
      tmr_r <= 16'h0000;
      cnt_r <= 10'h000;
      o_done <= 1'b0;
      o_status <= '0;
    end else begin
      o_done <= 1'b0;
      if (pdn_s && wr_state) begin
        st_r <= S_IDLE;
        o_done <= 1'b1;
        o_status <= '{range_err: 1'b0, id_err: 1'b0, crc_err: 1'b0, pwr_abort: 1'b1};
      end else begin
        case (st_r)
          S_RECAL: begin
            if (trk0_s) begin
              st_r <= S_IDLE;
              recal_r <= 1'b0;
            end else begin
              o_step_in <= 1'b0;
              tmr_r <= 16'(dsf_pkg::STEP_PULSE_CYC);
              st_r <= S_STEP;
            end
          end
          S_IDLE: begin
            cnt_r <= 10'h000;
            if (cmd_take) begin
              if (range_bad) begin
                o_done <= 1'b1;
                o_status <= '{range_err: 1'b1, id_err: 1'b0, crc_err: 1'b0, pwr_abort: 1'b0};
              end else begin
                st_r <= S_SEEK;
              end
            end
          end
          S_SEEK: begin
            if (cur_trk_r == tgt_trk_r) begin
              st_r <= (cmd_r.op == dsf_pkg::DSF_OP_FORMAT) ? S_HDR_WR : S_HDR_RD;
            end else begin
              o_step_in <= (tgt_trk_r > cur_trk_r);
              tmr_r <= 16'(dsf_pkg::STEP_PULSE_CYC);
              st_r <= S_STEP;
            end
          end
          S_STEP: begin
            tmr_r <= tmr_r - 16'h0001;
            if (tmr_r == 16'h0001) begin
              tmr_r <= 16'(dsf_pkg::STEP_GAP_CYC);
              st_r <= S_GAP;
            end
          end
          S_GAP: begin
            tmr_r <= tmr_r - 16'h0001;
            if (tmr_r == 16'h0001) begin
              st_r <= recal_r ? S_RECAL : S_SEEK;
            end
          end
          S_HDR_RD, S_HDR_WR: begin
            if (media_take | media_put) begin
              cnt_r <= cnt_r + 10'h001;
              if (cnt_r == 10'(dsf_pkg::HDR_BYTES - 1)) begin
                cnt_r <= 10'h000;
                st_r <= (st_r == S_HDR_RD) ? S_HCRC_RD : S_HCRC_WR;
              end
            end
          end
          S_HCRC_RD, S_DCRC_RD, S_HCRC_WR, S_DCRC_WR: begin
            if (media_take | media_put) begin
              cnt_r <= cnt_r + 10'h001;
              if (cnt_r == 10'(dsf_pkg::CRC_BYTES - 1)) begin
                cnt_r <= 10'h000;
                case (st_r)
                  S_HCRC_RD: st_r <= S_HCHK;
                  S_DCRC_RD: st_r <= S_DCHK;
                  S_HCRC_WR: st_r <= S_DAT_WR;
                  default: begin
                    st_r <= S_IDLE;
                    o_done <= 1'b1;
                    o_status <= '0;
                  end
                endcase
              end
            end
          end
          S_HCHK: begin
            if (crc != dsf_pkg::CRC_RESIDUE || id_bad_r) begin
              st_r <= S_IDLE;
              o_done <= 1'b1;
              o_status <= '{range_err: 1'b0, id_err: id_bad_r,
                            crc_err: (crc != dsf_pkg::CRC_RESIDUE), pwr_abort: 1'b0};
            end else begin
              st_r <= (cmd_r.op == dsf_pkg::DSF_OP_READ) ? S_DAT_RD : S_DAT_WR;
            end
          end
          S_DAT_RD, S_DAT_WR: begin
            if (media_take | media_put) begin
              cnt_r <= cnt_r + 10'h001;
              if (cnt_r == 10'(dsf_pkg::SECTOR_BYTES - 1)) begin
                cnt_r <= 10'h000;
                st_r <= (st_r == S_DAT_RD) ? S_DCRC_RD : S_DCRC_WR;
              end
            end
          end
          S_DCHK: begin
            st_r <= S_IDLE;
            o_done <= 1'b1;
            o_status <= '{range_err: 1'b0, id_err: 1'b0,
                          crc_err: (crc != dsf_pkg::CRC_RESIDUE), pwr_abort: 1'b0};
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  AST_STEP_IN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_STEP && tmr_r == 16'h0001 && o_step_in && !recal_r)
      |=> cur_trk_r == $past(cur_trk_r) + 8'h01) else $error("step in did not add one track");
  AST_STEP_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_STEP && tmr_r == 16'h0001 && !o_step_in && !recal_r)
      |=> cur_trk_r == $past(cur_trk_r) - 8'h01) else $error("step out did not drop one track");
  AST_TRACK_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_RECAL && trk0_s) |=> (cur_trk_r == 8'h00 && st_r == S_IDLE))
    else $error("track zero sensor did not set track zero");
  AST_SECTOR_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_DAT_WR && media_put && cnt_r == 10'h1ff && !pdn_s) |=> st_r == S_DCRC_WR)
    else $error("data field length not 512 bytes");
  AST_HDR_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r inside {S_DAT_RD, S_DAT_WR} && $past(st_r) != st_r)
      |-> $past(st_r) inside {S_HCHK, S_HCRC_WR}) else $error("data before header");
  AST_CRC_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_DCRC_WR && cnt_r == 10'h000 && o_media_wr_valid) |-> o_media_wr_byte == crc[15:8])
    else $error("check word high byte not first");
  AST_CRC_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_HDR_WR && media_put && cnt_r == 10'h004 && !pdn_s) |=> st_r == S_HCRC_WR)
    else $error("header check word not after header");
  AST_CRC_ERR: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_r == S_DCHK && crc != 16'h0000) |=> (o_done && o_status.crc_err))
    else $error("check word mismatch not reported");
  AST_NO_WRITE_PDN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    pdn_s |-> (!o_write_gate && !o_media_wr_valid)) else $error("write during power down");
  AST_SECTOR_RANGE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (cmd_take && !large_s && i_cmd.sector >= 5'h15) |=> (o_done && o_status.range_err))
    else $error("sector past track end accepted");
endmodule // dsf_framer

// *** dsf_drive_model.sv ***
// Behavioural sealed drive with stepped heads, track-zero sense and byte streams.
module dsf_drive_model (
  input wire logic i_sys_clk,
  input wire logic i_step,
  input wire logic i_step_in,
  input wire logic i_write_gate,
  output logic o_track0,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  input wire logic i_rd_ready,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  output logic o_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = 2;
  logic step_d = 1'b0;
  logic rd_take;
  integer seed = 32'h7e2fb650;
  logic [7:0] rd_q[$];
  logic [7:0] wr_q[$];
  assign o_track0 = (pos == 0);
  initial begin
    o_rd_valid = 1'b0;
    o_rd_byte = 8'h5a;
    o_wr_ready = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    // The heads settle on the new track as the step pulse ends.
    if (step_d && !i_step) pos = i_step_in ? pos + 1 : (pos > 0 ? pos - 1 : 0);
    step_d = i_step;
    rd_take = o_rd_valid && i_rd_ready;
    if (rd_take && rd_q.size() > 0) void'(rd_q.pop_front());
    // Only bytes offered while the write gate is open reach the media.
    if (i_wr_valid && o_wr_ready && i_write_gate) wr_q.push_back(i_wr_byte);
    #1;
    if (rd_q.size() > 0 && ((o_rd_valid && !rd_take) || ($random(seed) & 3) != 0)) begin
      o_rd_valid = 1'b1;
      o_rd_byte = rd_q[0];
    end else begin
      o_rd_valid = 1'b0;
      o_rd_byte = ~o_rd_byte;
    end
    o_wr_ready = ($random(seed) & 3) != 0;
  end
endmodule // dsf_drive_model

// *** tb_disk_sector_framer.sv ***
// Self-checking testbench for the disk sector framer.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module tb_disk_sector_framer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] dsf_bq_t[$];
  localparam logic [7:0] KEY = 8'h3c;
  localparam logic [7:0] SECI = 8'ha5;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_large_drive = 1'b0;
  logic i_power_down = 1'b0;
  logic i_cmd_valid = 1'b0;
  dsf_pkg::dsf_cmd_t i_cmd = '0;
  logic i_wr_valid = 1'b0;
  logic [7:0] i_wr_byte = 8'h00;
  logic i_rd_ready = 1'b0;
  logic o_cmd_ready, o_done, o_step, o_step_in, o_write_gate, o_media_rd_ready;
  logic o_media_wr_valid, o_wr_ready, o_rd_valid, track0, m_rd_valid, m_wr_ready;
  logic [2:0] o_head_sel;
  logic [7:0] o_cur_track, o_media_wr_byte, o_rd_byte, m_rd_byte;
  dsf_pkg::dsf_status_t o_status, st;
  integer seed = 32'h7e2fb650;
  int mismatches = 0;
  int check_count = 0;
  dsf_bq_t host_q, got_q, data, exp;
  int step_len = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  dsf_framer dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_large_drive(i_large_drive),
    .i_power_down(i_power_down), .i_track0(track0), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_status(o_status), .o_step(o_step),
    .o_step_in(o_step_in), .o_head_sel(o_head_sel), .o_cur_track(o_cur_track),
    .o_write_gate(o_write_gate), .i_media_rd_valid(m_rd_valid), .i_media_rd_byte(m_rd_byte),
    .o_media_rd_ready(o_media_rd_ready), .o_media_wr_valid(o_media_wr_valid),
    .o_media_wr_byte(o_media_wr_byte), .i_media_wr_ready(m_wr_ready), .i_wr_valid(i_wr_valid),
    .i_wr_byte(i_wr_byte), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
    .o_rd_byte(o_rd_byte), .i_rd_ready(i_rd_ready));

  dsf_drive_model model_u (.i_sys_clk(i_sys_clk), .i_step(o_step), .i_step_in(o_step_in),
    .i_write_gate(o_write_gate), .o_track0(track0), .o_rd_valid(m_rd_valid),
    .o_rd_byte(m_rd_byte), .i_rd_ready(o_media_rd_ready), .i_wr_valid(o_media_wr_valid),
    .i_wr_byte(o_media_wr_byte), .o_wr_ready(m_wr_ready));

  // Host side: feeds write data whenever any is queued and drains read data with random stalls.
  always @(posedge i_sys_clk) begin
    if (i_wr_valid && o_wr_ready === 1'b1) void'(host_q.pop_front());
    if (o_rd_valid === 1'b1 && i_rd_ready) got_q.push_back(o_rd_byte);
    #1;
    i_wr_valid = host_q.size() > 0;
    i_wr_byte = i_wr_valid ? host_q[0] : ~i_wr_byte;
    i_rd_ready = ($random(seed) & 3) != 0;
  end

  // Every step pulse to the drive must last the full pulse width.
  always @(negedge i_sys_clk) begin
    if (o_step === 1'b1) begin
      step_len++;
    end else if (step_len != 0) begin
      `CHK(step_len, dsf_pkg::STEP_PULSE_CYC)
      step_len = 0;
    end
  end

  function automatic logic [15:0] crc_of(input dsf_bq_t b);
    logic [15:0] c;
    c = dsf_pkg::CRC_INIT;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? dsf_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // Appends a field followed by its check word, high byte first.
  function automatic void add_field(ref dsf_bq_t q, input dsf_bq_t f);
    logic [15:0] c;
    c = crc_of(f);
    foreach (f[i]) q.push_back(f[i]);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
  endfunction

  function automatic dsf_bq_t mk_hdr(input logic [8:0] trk, input logic [2:0] hd,
                                     input logic [4:0] sec, input logic [7:0] key);
    return '{trk[7:0], {5'h00, hd}, key, {3'h0, sec}, SECI};
  endfunction

  task automatic fill_data();
    data = {};
    repeat (512) data.push_back(8'($random(seed)));
    host_q = data;
  endtask

  task automatic do_cmd(input dsf_pkg::dsf_op_t op, input logic [8:0] trk,
                        input logic [2:0] hd, input logic [4:0] sec);
    int n;
    @(posedge i_sys_clk);
    #1;
    i_cmd = '{op: op, track: trk, head: hd, sector: sec, key: KEY, secinfo: SECI};
    i_cmd_valid = 1'b1;
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    @(posedge i_sys_clk);
    #1;
    i_cmd_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n >= 20000 || o_done !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t command never finished", $time);
    end
    st = o_status;
    repeat (16) @(posedge i_sys_clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1 i_resetn = 1'b1;
    for (int n = 0; n < 10000 && o_cmd_ready !== 1'b1; n++) @(posedge i_sys_clk);
    `CHK(o_cmd_ready, 1'b1)
    `CHK(o_cur_track, 8'h00)
    `CHK(model_u.pos, 0)
    fill_data();
    model_u.wr_q = {};
    // Sector seven is laid down first, as a skewed track layout would order it.
    do_cmd(dsf_pkg::DSF_OP_FORMAT, 9'h002, 3'h5, 5'h07);
    `CHK(st, 4'h0)
    `CHK(model_u.pos, 2)
    `CHK(o_cur_track, 8'h02)
    `CHK(o_step_in, 1'b1)
    `CHK(o_head_sel, 3'h5)
    exp = {};
    add_field(exp, mk_hdr(9'h002, 3'h5, 5'h07, KEY));
    add_field(exp, data);
    `CHK(model_u.wr_q.size(), 521)
    foreach (exp[i]) `CHK(model_u.wr_q[i], exp[i])
    model_u.rd_q = exp;
    got_q = {};
    do_cmd(dsf_pkg::DSF_OP_READ, 9'h002, 3'h5, 5'h07);
    `CHK(st, 4'h0)
    `CHK(got_q.size(), 512)
    foreach (data[i]) `CHK(got_q[i], data[i])
    model_u.rd_q = exp;
    model_u.rd_q[100] = ~exp[100];
    do_cmd(dsf_pkg::DSF_OP_READ, 9'h002, 3'h5, 5'h07);
    `CHK(st.crc_err, 1'b1)
    model_u.rd_q = {};
    add_field(model_u.rd_q, mk_hdr(9'h002, 3'h5, 5'h07, ~KEY));
    got_q = {};
    do_cmd(dsf_pkg::DSF_OP_READ, 9'h002, 3'h5, 5'h07);
    `CHK(st.id_err, 1'b1)
    `CHK(got_q.size(), 0)
    model_u.rd_q = exp[0:6];
    model_u.wr_q = {};
    fill_data();
    exp = {};
    add_field(exp, data);
    do_cmd(dsf_pkg::DSF_OP_WRITE, 9'h002, 3'h5, 5'h07);
    `CHK(model_u.wr_q.size(), 514)
    foreach (exp[i]) `CHK(model_u.wr_q[i], exp[i])
    do_cmd(dsf_pkg::DSF_OP_READ, 9'h000, 3'h0, 5'h15);
    `CHK(st.range_err, 1'b1)
    #1 i_large_drive = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    do_cmd(dsf_pkg::DSF_OP_READ, 9'h000, 3'h4, 5'h00);
    `CHK(st.range_err, 1'b1)
    fill_data();
    do_cmd(dsf_pkg::DSF_OP_FORMAT, 9'h0cb, 3'h1, 5'h1f);
    `CHK(st, 4'h0)
    `CHK(o_head_sel, 3'h3)
    `CHK(model_u.pos, 1)
    `CHK(o_cur_track, 8'h01)
    `CHK(o_step_in, 1'b0)
    fill_data();
    model_u.wr_q = {};
    fork
      do_cmd(dsf_pkg::DSF_OP_FORMAT, 9'h000, 3'h0, 5'h00);
      begin
        for (int n = 0; n < 20000 && model_u.wr_q.size() < 100; n++) @(posedge i_sys_clk);
        #1 i_power_down = 1'b1;
      end
    join
    `CHK(st.pwr_abort, 1'b1)
    `CHK(o_write_gate, 1'b0)
    `CHK(model_u.wr_q.size() < 521, 1'b1)
    final_report();
  end
endmodule // tb_disk_sector_framer
